/* File: design/dsw_pkg.sv */
/*
  dual stage watchdog: shared constants, register map and types.
  assumes a 32-bit apb slave port and a 100 mhz mclk.
*/
`default_nettype none

package dsw_pkg;

  // ****************************************************************
  // bus and register map
  // ****************************************************************
  localparam int          DSW_AW       = 8;
  localparam int          DSW_DW       = 32;
  localparam logic [7:0]  DSW_OFF_CTRL = 8'h00;
  localparam logic [7:0]  DSW_OFF_TO1  = 8'h04;
  localparam logic [7:0]  DSW_OFF_TO2  = 8'h08;
  localparam logic [7:0]  DSW_OFF_SVC  = 8'h0c;
  localparam logic [7:0]  DSW_OFF_STS  = 8'h10;
  localparam logic [7:0]  DSW_OFF_MSK  = 8'h14;
  localparam logic [7:0]  DSW_OFF_STAT = 8'h18;
  localparam logic [7:0]  DSW_OFF_CNT  = 8'h1c;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int          DSW_CTRL_W   = 8;
  localparam int          DSW_EV_W     = 3;
  localparam int          DSW_EV_STG1  = 0;
  localparam int          DSW_EV_STG2  = 1;
  localparam int          DSW_EV_REJ   = 2;
  localparam logic [31:0] DSW_TO1_RST  = 32'h05f5_e100;
  localparam logic [31:0] DSW_TO2_RST  = 32'h05f5_e100;
  localparam logic [31:0] DSW_CNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] DSW_CNT_ONE  = 32'h0000_0001;
  localparam logic [31:0] DSW_RD_ZERO  = 32'h0000_0000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    DSW_ACT_RESET   = 3'h0,
    DSW_ACT_NMI     = 3'h1,
    DSW_ACT_SCI     = 3'h2,
    DSW_ACT_DELAY   = 3'h3,
    DSW_ACT_PIN     = 3'h4,
    DSW_ACT_CASCADE = 3'h5
  } dsw_act_t;

  typedef struct packed {
    dsw_act_t act2;
    dsw_act_t act1;
    logic     pin_sel;
    logic     en;
  } dsw_ctrl_t;

  localparam dsw_ctrl_t DSW_CTRL_RST = '{act2: DSW_ACT_RESET, act1: DSW_ACT_RESET,
                                         pin_sel: 1'b0, en: 1'b0};

  typedef enum logic [1:0] {
    DSW_IDLE = 2'b00,
    DSW_RUN1 = 2'b01,
    DSW_RUN2 = 2'b11,
    DSW_HALT = 2'b10
  } dsw_state_t;

endpackage

`default_nettype wire

/* File: design/dsw_flag.sv */
/*
  dual stage watchdog: bank of sticky event flags, write one to clear.
  assumes set and clear are single-cycle strobes from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dsw_flag #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // events and clears
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flags
  output logic      [W-1:0] flags
);

  // ****************************************************************
  // sticky bits, a set wins over a clear in the same cycle
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags <= '0;
    end
    else
    begin
      flags <= (flags & ~clr) | set;
    end
  end

endmodule

`default_nettype wire

/* File: design/dsw_stage.sv */
/*
  dual stage watchdog: one down-counting time-out stage.
  assumes load and run come from the owning state machine.
*/
`timescale 1ns/1ps
`default_nettype none

module dsw_stage (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // control
  input  wire logic        load,
  input  wire logic        run,
  input  wire logic [31:0] load_val,
  // state
  output logic      [31:0] count,
  output logic             expired
);
  import dsw_pkg::*;

  // ****************************************************************
  // down counter
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= DSW_CNT_ZERO;
    end
    else if (load)
    begin
      count <= load_val;
    end
    else if (run && count != DSW_CNT_ZERO)
    begin
      count <= count - DSW_CNT_ONE;
    end
  end

  assign expired = run & ~load & (count == DSW_CNT_ZERO);

endmodule

`default_nettype wire

/* File: design/dsw_top.sv */
/*
  dual stage watchdog: apb registers, stage sequencing, actions, pin, irq.
  assumes apb master on mclk; action outputs go to host reset and irq logic.
*/
`timescale 1ns/1ps
`default_nettype none

module dsw_top (
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [dsw_pkg::DSW_AW-1:0]   paddr,
  input  wire logic [dsw_pkg::DSW_DW-1:0]   pwdata,
  output logic      [dsw_pkg::DSW_DW-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  // actions
  output logic                              reset_req,
  output logic                              nmi_req,
  output logic                              sci_req,
  output logic                              watchdog_output_pin,
  output logic                              irq
);
  import dsw_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  dsw_ctrl_t            ctrl_q;
  dsw_ctrl_t            ctrl_d;
  dsw_state_t           state_q;
  dsw_state_t           state_d;
  logic [31:0]          to1_q;
  logic [31:0]          to2_q;
  logic [DSW_EV_W-1:0]  mask_q;
  logic [DSW_EV_W-1:0]  sts;
  logic [DSW_EV_W-1:0]  ev_set;
  logic [DSW_EV_W-1:0]  ev_clr;
  logic [31:0]          cnt1;
  logic [31:0]          cnt2;
  logic                 exp1;
  logic                 exp2;
  logic                 load1;
  logic                 load2;
  logic                 run1;
  logic                 run2;
  logic                 wr_en;
  logic                 setup;
  logic                 mapped;
  logic                 service;
  logic                 fire1;
  logic                 fire2;
  logic                 rej;
  logic                 pin_fire;
  logic [31:0]          rd_data;
  logic                 reset_req_q;
  logic                 nmi_req_q;
  logic                 sci_req_q;
  logic                 pin_q;
  logic                 irq_q;
  logic [31:0]          prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pready_q & pwrite;
  assign service = wr_en & (paddr == DSW_OFF_SVC) & ctrl_q.en;

  always_comb
  begin
    unique case (paddr)
      DSW_OFF_CTRL, DSW_OFF_TO1, DSW_OFF_TO2, DSW_OFF_SVC,
      DSW_OFF_STS, DSW_OFF_MSK, DSW_OFF_STAT, DSW_OFF_CNT: mapped = 1'b1;
      default:                                             mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    rd_data = DSW_RD_ZERO;
    unique case (paddr)
      DSW_OFF_CTRL: rd_data[DSW_CTRL_W-1:0] = ctrl_q;
      DSW_OFF_TO1:  rd_data = to1_q;
      DSW_OFF_TO2:  rd_data = to2_q;
      DSW_OFF_STS:  rd_data[DSW_EV_W-1:0] = sts;
      DSW_OFF_MSK:  rd_data[DSW_EV_W-1:0] = mask_q;
      DSW_OFF_STAT: rd_data[2:0] = {pin_q, state_q};
      DSW_OFF_CNT:  rd_data = run2 ? cnt2 : cnt1;
      default:      rd_data = DSW_RD_ZERO;
    endcase
  end

  // answer in the first access cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= DSW_RD_ZERO;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup && !pwrite)
      begin
        prdata_q <= rd_data;
      end
    end
  end

  // ****************************************************************
  // control and time-out registers
  // ****************************************************************
  always_comb
  begin
    ctrl_d = ctrl_q;
    rej    = 1'b0;
    if (wr_en && paddr == DSW_OFF_CTRL)
    begin
      ctrl_d.en      = pwdata[0];
      ctrl_d.pin_sel = pwdata[1];
      if (pwdata[4:2] <= DSW_ACT_CASCADE)
      begin
        ctrl_d.act1 = dsw_act_t'(pwdata[4:2]);
      end
      else
      begin
        rej = 1'b1;
      end
      if (pwdata[7:5] <= DSW_ACT_CASCADE && pwdata[7:5] != DSW_ACT_DELAY)
      begin
        ctrl_d.act2 = dsw_act_t'(pwdata[7:5]);
      end
      else
      begin
        rej = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= DSW_CTRL_RST;
      to1_q  <= DSW_TO1_RST;
      to2_q  <= DSW_TO2_RST;
      mask_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      if (wr_en && paddr == DSW_OFF_TO1)
      begin
        to1_q <= pwdata;
      end
      if (wr_en && paddr == DSW_OFF_TO2)
      begin
        to2_q <= pwdata;
      end
      if (wr_en && paddr == DSW_OFF_MSK)
      begin
        mask_q <= pwdata[DSW_EV_W-1:0];
      end
    end
  end

  // ****************************************************************
  // stage sequencing
  // ****************************************************************
  assign run1  = (state_q == DSW_RUN1);
  assign run2  = (state_q == DSW_RUN2);
  assign fire1 = exp1 & ctrl_q.en & ~service;
  assign fire2 = exp2 & ctrl_q.en & ~service;
  assign load1 = ctrl_q.en & ((state_q == DSW_IDLE) | service);
  assign load2 = fire1 & (ctrl_q.act1 == DSW_ACT_CASCADE
                          || ctrl_q.act1 == DSW_ACT_DELAY);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      DSW_IDLE:
      begin
        if (ctrl_q.en)
        begin
          state_d = DSW_RUN1;
        end
      end
      DSW_RUN1:
      begin
        if (!ctrl_q.en)
        begin
          state_d = DSW_IDLE;
        end
        else if (load2)
        begin
          state_d = DSW_RUN2;
        end
        else if (fire1)
        begin
          state_d = DSW_HALT;
        end
      end
      DSW_RUN2, DSW_HALT:
      begin
        if (!ctrl_q.en)
        begin
          state_d = DSW_IDLE;
        end
        else if (service)
        begin
          state_d = DSW_RUN1;
        end
        else if (fire2)
        begin
          state_d = DSW_HALT;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= DSW_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  dsw_stage u_stage1 (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .load     (load1),
    .run      (run1),
    .load_val (to1_q),
    .count    (cnt1),
    .expired  (exp1)
  );

  dsw_stage u_stage2 (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .load     (load2),
    .run      (run2),
    .load_val (to2_q),
    .count    (cnt2),
    .expired  (exp2)
  );

  // ****************************************************************
  // expiry actions
  // ****************************************************************
  assign pin_fire = ctrl_q.pin_sel ? fire2
                  : (fire1 & ctrl_q.act1 != DSW_ACT_DELAY);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reset_req_q <= 1'b0;
      nmi_req_q   <= 1'b0;
      sci_req_q   <= 1'b0;
    end
    else
    begin
      reset_req_q <= (fire1 & ctrl_q.act1 == DSW_ACT_RESET)
                   | (fire2 & ctrl_q.act2 == DSW_ACT_RESET);
      nmi_req_q   <= (fire1 & ctrl_q.act1 == DSW_ACT_NMI)
                   | (fire2 & ctrl_q.act2 == DSW_ACT_NMI);
      sci_req_q   <= (fire1 & ctrl_q.act1 == DSW_ACT_SCI)
                   | (fire2 & ctrl_q.act2 == DSW_ACT_SCI);
    end
  end

  // pin is released only by reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_q <= 1'b0;
    end
    else
    begin
      pin_q <= pin_q | pin_fire;
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  always_comb
  begin
    ev_set              = '0;
    ev_set[DSW_EV_STG1] = fire1;
    ev_set[DSW_EV_STG2] = fire2;
    ev_set[DSW_EV_REJ]  = rej;
    ev_clr              = (wr_en && paddr == DSW_OFF_STS) ? pwdata[DSW_EV_W-1:0] : '0;
  end

  dsw_flag #(.W(DSW_EV_W)) u_flags (
    .mclk  (mclk),
    .rst_n (rst_n),
    .set   (ev_set),
    .clr   (ev_clr),
    .flags (sts)
  );

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(sts & mask_q);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign reset_req           = reset_req_q;
  assign nmi_req             = nmi_req_q;
  assign sci_req             = sci_req_q;
  assign watchdog_output_pin = pin_q;
  assign irq                 = irq_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_stage_order: assert property (
    (state_q == DSW_RUN2) |-> ($past(state_q) == DSW_RUN1 || $past(state_q) == DSW_RUN2))
    else $error("stage two entered without stage one");

  chk_service_reload: assert property (
    (service && ctrl_d.en && state_q != DSW_IDLE) |=> (state_q == DSW_RUN1 && cnt1 == $past(to1_q)))
    else $error("service did not reload stage one");

  chk_reset_act: assert property (
    (fire1 && ctrl_q.act1 == DSW_ACT_RESET) |=> reset_req ##1 !reset_req)
    else $error("reset request not a single pulse after expiry");

  chk_nmi_act: assert property (
    (fire2 && ctrl_q.act2 == DSW_ACT_NMI) |=> (nmi_req && !reset_req && !sci_req))
    else $error("nmi request missing after stage two expiry");

  chk_sci_act: assert property (
    (fire1 && ctrl_q.act1 == DSW_ACT_SCI) |=> (sci_req && !nmi_req && !reset_req))
    else $error("sci request missing after stage one expiry");

  chk_no_delay2: assert property (
    (wr_en && paddr == DSW_OFF_CTRL && pwdata[7:5] == DSW_ACT_DELAY)
      |=> (ctrl_q.act2 == $past(ctrl_q.act2) && sts[DSW_EV_REJ]))
    else $error("delay accepted for stage two");

  chk_pin_only: assert property (
    (fire1 && ctrl_q.act1 == DSW_ACT_PIN && !ctrl_q.pin_sel)
      |=> (watchdog_output_pin && !reset_req && !nmi_req && !sci_req && state_q != DSW_RUN2))
    else $error("signal-only expiry did more than drive the pin");

  chk_cascade: assert property (
    (fire1 && ctrl_q.act1 == DSW_ACT_CASCADE && ctrl_d.en)
      |=> (state_q == DSW_RUN2 && cnt2 == $past(to2_q) && !reset_req && !nmi_req && !sci_req))
    else $error("cascade did not start stage two");

  chk_pin_stage: assert property (
    (fire2 && ctrl_q.pin_sel) |=> watchdog_output_pin)
    else $error("pin not asserted on its stage expiry");

  chk_pin_hold: assert property (
    watchdog_output_pin |=> watchdog_output_pin [*3])
    else $error("pin released without reset");

  chk_count_down: assert property (
    (run1 && !load1 && cnt1 != DSW_CNT_ZERO && state_d == DSW_RUN1)
      |=> (cnt1 == $past(cnt1) - DSW_CNT_ONE))
    else $error("stage one did not count down");

  chk_irq_level: assert property (
    (|(sts & mask_q)) |=> irq)
    else $error("interrupt not raised for unmasked status");

  cov_cascade_expiry: cover property (
    (state_q == DSW_RUN2) ##[1:1000] (fire2 && ctrl_q.act2 == DSW_ACT_RESET));

  cov_service_run2: cover property (run2 && service);

  cov_reject: cover property (rej);

  cov_nmi_stage1: cover property (fire1 && ctrl_q.act1 == DSW_ACT_NMI);

endmodule

`default_nettype wire

/* File: tb/dsw_host_model.sv */
/*
  host side of the watchdog: tallies restart, nmi and sci requests.
  assumes one-cycle request pulses on mclk; counts every cycle a request is high.
*/
`timescale 1ns/1ps
`default_nettype none

module dsw_host_model (
  // clock
  input  wire logic mclk,
  // requests from the watchdog
  input  wire logic reset_req,
  input  wire logic nmi_req,
  input  wire logic sci_req,
  // tallies
  output var  int   n_rst,
  output var  int   n_nmi,
  output var  int   n_sci
);
  // ****************************************************************
  // request tallies
  // ****************************************************************
  initial
  begin
    n_rst = 0;
    n_nmi = 0;
    n_sci = 0;
  end

  // a request held too long counts twice and shows as a mismatch
  always @(posedge mclk)
  begin
    if (reset_req === 1'b1)
      n_rst <= n_rst + 1;
    if (nmi_req === 1'b1)
      n_nmi <= n_nmi + 1;
    if (sci_req === 1'b1)
      n_sci <= n_sci + 1;
  end
endmodule

`default_nettype wire

/* File: tb/dual_stage_watchdog_bench.sv */
/*
  bench for the dual stage watchdog: apb master, reference tallies, scenarios.
  assumes dsw_top and dsw_host_model; 100 mhz mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module dual_stage_watchdog_bench;
  import dsw_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic        mclk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        reset_req;
  logic        nmi_req;
  logic        sci_req;
  logic        watchdog_output_pin;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          n_rst;
  int          n_nmi;
  int          n_sci;
  int          exp_rst = 0;
  int          exp_nmi = 0;
  int          exp_sci = 0;
  int          bad_count = 0;
  int          n_tests = 0;
  int          seed;
  int          t1;
  int          t2;
  int          u_codes[4] = '{0, 1, 2, 4};

  dsw_top u_dsw_top (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_req(reset_req), .nmi_req(nmi_req), .sci_req(sci_req),
    .watchdog_output_pin(watchdog_output_pin), .irq(irq)
  );

  dsw_host_model u_dsw_host_model (
    .mclk(mclk), .reset_req(reset_req), .nmi_req(nmi_req), .sci_req(sci_req),
    .n_rst(n_rst), .n_nmi(n_nmi), .n_sci(n_sci)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd       = prdata;
    err      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
  endtask

  function automatic logic [31:0] ctrl(int a1, int a2, logic ps, logic en);
    dsw_ctrl_t c;
    c.act2    = dsw_act_t'(a2[2:0]);
    c.act1    = dsw_act_t'(a1[2:0]);
    c.pin_sel = ps;
    c.en      = en;
    return 32'(c);
  endfunction

  // pre: cycles with no action yet; then 8 cycles for the action to land
  task automatic expire_check(input int pre, input int code, input logic pp, input logic pq);
    repeat (pre) @(posedge mclk);
    chk(n_rst + n_nmi + n_sci, exp_rst + exp_nmi + exp_sci);
    chk(watchdog_output_pin, pp);
    repeat (8) @(posedge mclk);
    exp_rst += (code == 0);
    exp_nmi += (code == 1);
    exp_sci += (code == 2);
    chk(n_rst, exp_rst);
    chk(n_nmi, exp_nmi);
    chk(n_sci, exp_sci);
    chk(watchdog_output_pin, pq);
  endtask

  task automatic run(input int a1, input int a2, input logic ps, input int ta, input int tb);
    logic ch;
    ch = (a1 == 3 || a1 == 5);
    do_reset();
    apb(1'b1, DSW_OFF_TO1, 32'(ta));
    apb(1'b1, DSW_OFF_TO2, 32'(tb));
    apb(1'b1, DSW_OFF_CTRL, ctrl(a1, a2, ps, 1'b1));
    expire_check(ch ? ta + tb : ta, ch ? a2 : a1, a1 == 5 && !ps, ps ? ch : a1 != 3);
    rchk(DSW_OFF_STS, ch ? 32'h3 : 32'h1);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    seed    = 10;
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    do_reset();
    rchk(DSW_OFF_CTRL, 32'h0);
    rchk(DSW_OFF_TO1, DSW_TO1_RST);
    rchk(DSW_OFF_TO2, DSW_TO2_RST);
    rchk(DSW_OFF_MSK, 32'h0);
    rchk(DSW_OFF_SVC, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // every single-stage action, random time-outs
    foreach (u_codes[i])
    begin
      t1 = 4 + $unsigned($random(seed)) % 16;
      run(u_codes[i], 0, 1'b0, t1, 4);
    end
    // pin stays through disable and service, clears on reset
    apb(1'b1, DSW_OFF_CTRL, 32'h0);
    apb(1'b1, DSW_OFF_SVC, 32'h0);
    chk(watchdog_output_pin, 1'b1);
    do_reset();
    repeat (2) @(posedge mclk);
    chk(watchdog_output_pin, 1'b0);
    // chained stages: delay and cascade, pin on either stage
    for (int i = 0; i < 4; i++)
    begin
      t1 = 4 + $unsigned($random(seed)) % 16;
      t2 = 4 + $unsigned($random(seed)) % 16;
      run(i[0] ? 5 : 3, i == 1 ? 1 : (i == 2 ? 4 : 2 * (i & 1) + 2 * ((i >> 1) & 1) - 2 * i / 3),
          i[1], t1, t2);
    end
    // mask, level interrupt, write one to clear
    apb(1'b1, DSW_OFF_MSK, 32'h2);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    apb(1'b1, DSW_OFF_MSK, 32'h0);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    apb(1'b1, DSW_OFF_MSK, 32'h3);
    apb(1'b1, DSW_OFF_STS, 32'h3);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    rchk(DSW_OFF_STS, 32'h0);
    // delay refused for stage two, other fields still written
    do_reset();
    apb(1'b1, DSW_OFF_CTRL, ctrl(1, 2, 1'b0, 1'b0));
    apb(1'b1, DSW_OFF_CTRL, ctrl(1, 3, 1'b1, 1'b0));
    rchk(DSW_OFF_CTRL, ctrl(1, 2, 1'b1, 1'b0));
    rchk(DSW_OFF_STS, 32'h4);
    // regular service holds off expiry, then expiry once it stops
    do_reset();
    apb(1'b1, DSW_OFF_TO1, 32'd12);
    apb(1'b1, DSW_OFF_CTRL, ctrl(1, 0, 1'b0, 1'b1));
    repeat (6)
    begin
      repeat (5) @(posedge mclk);
      apb(1'b1, DSW_OFF_SVC, 32'h0);
    end
    expire_check(12, 1, 1'b0, 1'b1);
    // service during stage two cancels it
    do_reset();
    apb(1'b1, DSW_OFF_TO1, 32'd10);
    apb(1'b1, DSW_OFF_TO2, 32'd60);
    apb(1'b1, DSW_OFF_CTRL, ctrl(5, 1, 1'b1, 1'b1));
    repeat (16) @(posedge mclk);
    rchk(DSW_OFF_STAT, 32'h3);
    rchk(DSW_OFF_CNT, 32'd52);
    apb(1'b1, DSW_OFF_SVC, 32'h0);
    rchk(DSW_OFF_STAT, 32'h1);
    tally_and_finish();
  end

  initial
  begin
    repeat (50000) @(posedge mclk);
    bad_count++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
